//--- pps_pkg.sv
// pps_pkg: offsets, field positions and reset values of the port status bank
// assumes byte offsets of 16-bit registers as seen on the parallel host port
package pps_pkg;
    localparam int unsigned DW = 16;
    localparam int unsigned AW = 12;
    localparam logic [11:0] OFF_P2_BASIC = 12'h005a;
    localparam logic [11:0] OFF_P2_ID_LO = 12'h005c;
    localparam logic [11:0] OFF_P2_ID_HI = 12'h005e;
    localparam logic [11:0] OFF_P2_ADV = 12'h0060;
    localparam logic [11:0] OFF_P2_PARTNER = 12'h0062;
    localparam logic [11:0] OFF_RSV_A = 12'h0064;
    localparam logic [11:0] OFF_P1_SPECIAL = 12'h0066;
    localparam logic [11:0] OFF_RSV_B = 12'h0068;
    localparam logic [11:0] OFF_P2_SPECIAL = 12'h006a;
    // identifier words: arbitrary neutral values
    localparam logic [15:0] ID_LO_VAL = 16'h5a5a;
    localparam logic [15:0] ID_HI_VAL = 16'h00a5;
    // fixed basic status bits: 14..11 capabilities, 3 aneg capable
    localparam logic [15:0] BASIC_FIXED = 16'h7808;
    localparam int unsigned B_ANEG_DONE = 5;
    localparam int unsigned B_LINK_UP = 2;
    // advertisement: selector field and writable mask
    localparam logic [15:0] ADV_SELECTOR = 16'h0001;
    localparam logic [15:0] ADV_WMASK = 16'h05e0;
    localparam logic [15:0] ADV_RESET = 16'h05e0;
    localparam int unsigned ADV_PAUSE = 10;
    localparam int unsigned ADV_ABIL_LO = 5;
    localparam logic [15:0] PARTNER_FIXED = 16'h0001;
    // special control/status layout
    localparam int unsigned S_POL_REV = 5;
    localparam int unsigned S_MDIX = 4;
    localparam int unsigned S_FORCE_LINK = 3;
    localparam int unsigned S_LP10_DIS = 2;
    localparam int unsigned S_NEAR_LOOP = 1;
    localparam logic [15:0] SPEC_WMASK = 16'h000e;
    localparam logic [15:0] SPEC_RESET = 16'h0004;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [3:0] ZERO4 = 4'h0;
    localparam int unsigned NPORT = 2;
endpackage

//--- pps_status_regs.sv
// pps_status_regs: host register bank for phy port status and special control
// assumes host strobes are synchronous to clock; phy status pins are not
//
// Contract
// - basic status capability bits fixed, t4 zero
// - basic status bit5 shows negotiation complete
// - basic status bit2 shows link up
// - basic status bit3 always one
// - preamble, jabber, extended bits read zero
// - two fixed read-only identifier words
// - advert pause bit writable, resets one, shared
// - advert ability bits 8..5 writable, reset one
// - next page, remote fault zero; selector one
// - partner pause bit mirrors partner status
// - partner ability bits mirror status, reset zero
// - special bit5 reports reversed polarity
// - special bit4 reports crossover state
// - force link bit writable, resets zero
// - low power 10mb disable bit resets one
// - near end loopback bit resets zero
// - reserved gaps decode with no function
// - port2 special register mirrors port1 layout
`timescale 1ns/1ps
module pps_status_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // host access
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [pps_pkg::AW-1:0] host_addr,
    input wire logic [pps_pkg::DW-1:0] host_wdata,
    output logic [pps_pkg::DW-1:0] host_rdata,
    output logic host_rvalid,
    // phy status, per port (index 0 = port1, 1 = port2)
    input wire logic [pps_pkg::NPORT-1:0] phy_aneg_done,
    input wire logic [pps_pkg::NPORT-1:0] phy_link_up,
    input wire logic [pps_pkg::NPORT-1:0] phy_pol_rev,
    input wire logic [pps_pkg::NPORT-1:0] phy_mdix,
    input wire logic [pps_pkg::NPORT-1:0] partner_pause,
    input wire logic [pps_pkg::NPORT*4-1:0] partner_abil,
    // controls to the phy, per port except the shared advertisement pause and ability
    output logic [pps_pkg::NPORT-1:0] force_link,
    output logic [pps_pkg::NPORT-1:0] low_power_10mb_mode_dis,
    output logic [pps_pkg::NPORT-1:0] near_loopback,
    output logic adv_pause,
    output logic [3:0] adv_abil
);
    import pps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [NPORT-1:0] an_m;
        logic [NPORT-1:0] an_s;
        logic [NPORT-1:0] lk_m;
        logic [NPORT-1:0] lk_s;
        logic [NPORT-1:0] pol_m;
        logic [NPORT-1:0] pol_s;
        logic [NPORT-1:0] mx_m;
        logic [NPORT-1:0] mx_s;
        logic pp_m;
        logic pp_s;
        logic [3:0] pa_m;
        logic [3:0] pa_s;
        logic [15:0] adv;
        logic [15:0] spec1;
        logic [15:0] spec2;
        logic [15:0] rdata;
        logic rvalid;
    } pps_state_t;

    pps_state_t st_r;
    pps_state_t st_nxt;
    logic [15:0] basic_w;
    logic [15:0] partner_w;
    logic [15:0] spec1_rd;
    logic [15:0] spec2_rd;

    ////////////////////////////////////////////////////////////////////////////
    // read views
    always_comb begin
        basic_w = BASIC_FIXED;
        basic_w[B_ANEG_DONE] = st_r.an_s[1];
        basic_w[B_LINK_UP] = st_r.lk_s[1];
        partner_w = PARTNER_FIXED;
        partner_w[ADV_PAUSE] = st_r.pp_s;
        partner_w[ADV_ABIL_LO+3:ADV_ABIL_LO] = st_r.pa_s;
        spec1_rd = st_r.spec1;
        spec1_rd[S_POL_REV] = st_r.pol_s[0];
        spec1_rd[S_MDIX] = st_r.mx_s[0];
        spec2_rd = st_r.spec2;
        spec2_rd[S_POL_REV] = st_r.pol_s[1];
        spec2_rd[S_MDIX] = st_r.mx_s[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        // two-flop synchronisers on phy status
        st_nxt.an_m = phy_aneg_done;
        st_nxt.an_s = st_r.an_m;
        st_nxt.lk_m = phy_link_up;
        st_nxt.lk_s = st_r.lk_m;
        st_nxt.pol_m = phy_pol_rev;
        st_nxt.pol_s = st_r.pol_m;
        st_nxt.mx_m = phy_mdix;
        st_nxt.mx_s = st_r.mx_m;
        st_nxt.pp_m = partner_pause[1];
        st_nxt.pp_s = st_r.pp_m;
        st_nxt.pa_m = partner_abil[7:4];
        st_nxt.pa_s = st_r.pa_m;
        // writes touch only the writable masks
        if (host_wr) begin
            if (host_addr == OFF_P2_ADV) begin
                st_nxt.adv = (st_r.adv & ~ADV_WMASK) | (host_wdata & ADV_WMASK);
            end else if (host_addr == OFF_P1_SPECIAL) begin
                st_nxt.spec1 = (st_r.spec1 & ~SPEC_WMASK) | (host_wdata & SPEC_WMASK);
            end else if (host_addr == OFF_P2_SPECIAL) begin
                st_nxt.spec2 = (st_r.spec2 & ~SPEC_WMASK) | (host_wdata & SPEC_WMASK);
            end
        end
        // read decode, one cycle latency
        st_nxt.rvalid = host_rd;
        if (!host_rd) begin
            st_nxt.rdata = ZERO16;
        end else if (host_addr == OFF_P2_BASIC) begin
            st_nxt.rdata = basic_w;
        end else if (host_addr == OFF_P2_ID_LO) begin
            st_nxt.rdata = ID_LO_VAL;
        end else if (host_addr == OFF_P2_ID_HI) begin
            st_nxt.rdata = ID_HI_VAL;
        end else if (host_addr == OFF_P2_ADV) begin
            st_nxt.rdata = st_r.adv;
        end else if (host_addr == OFF_P2_PARTNER) begin
            st_nxt.rdata = partner_w;
        end else if (host_addr == OFF_P1_SPECIAL) begin
            st_nxt.rdata = spec1_rd;
        end else if (host_addr == OFF_P2_SPECIAL) begin
            st_nxt.rdata = spec2_rd;
        end else begin
            st_nxt.rdata = ZERO16;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.adv <= ADV_RESET | ADV_SELECTOR;
            st_r.spec1 <= SPEC_RESET;
            st_r.spec2 <= SPEC_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign host_rdata = st_r.rdata;
    assign host_rvalid = st_r.rvalid;
    assign force_link = {st_r.spec2[S_FORCE_LINK], st_r.spec1[S_FORCE_LINK]};
    assign low_power_10mb_mode_dis = {st_r.spec2[S_LP10_DIS], st_r.spec1[S_LP10_DIS]};
    assign near_loopback = {st_r.spec2[S_NEAR_LOOP], st_r.spec1[S_NEAR_LOOP]};
    assign adv_pause = st_r.adv[ADV_PAUSE];
    assign adv_abil = st_r.adv[ADV_ABIL_LO+3:ADV_ABIL_LO];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_read_basic;
        host_rd && host_addr == OFF_P2_BASIC;
    endsequence
    sequence s_read_adv;
        host_rd && host_addr == OFF_P2_ADV;
    endsequence
    sequence s_read_partner;
        host_rd && host_addr == OFF_P2_PARTNER;
    endsequence
    sequence s_read_spec1;
        host_rd && host_addr == OFF_P1_SPECIAL;
    endsequence
    sequence s_read_spec2;
        host_rd && host_addr == OFF_P2_SPECIAL;
    endsequence

    // status held long enough to pass the synchroniser
    sequence s_link_up_steady;
        phy_link_up[1] [*3];
    endsequence
    sequence s_link_down_steady;
        !phy_link_up[1] [*3];
    endsequence
    sequence s_aneg_up_steady;
        phy_aneg_done[1] [*3];
    endsequence
    sequence s_aneg_down_steady;
        !phy_aneg_done[1] [*3];
    endsequence

    a_basic_fixed: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_basic |=> (host_rdata & 16'hf84b) == 16'h7808)
        else $error("basic status fixed bits wrong");
    a_basic_aneg: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_basic |=> host_rdata[5] == $past(st_r.an_s[1]))
        else $error("aneg done bit wrong");
    a_basic_link: assert property (@(posedge clock) disable iff (!rst_b)
        phy_link_up[1] [*3] ##0 s_read_basic |=> host_rdata[2])
        else $error("link bit wrong");
    a_basic_capable: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_basic |=> host_rdata[3] && !host_rdata[6] && !host_rdata[0])
        else $error("aneg capable bit wrong");
    a_ident_fixed: assert property (@(posedge clock) disable iff (!rst_b)
        host_rd && host_addr == OFF_P2_ID_LO |=> host_rdata == ID_LO_VAL)
        else $error("ident low wrong");
    a_adv_write: assert property (@(posedge clock) disable iff (!rst_b)
        host_wr && host_addr == OFF_P2_ADV |=> adv_pause == $past(host_wdata[10])
            && adv_abil == $past(host_wdata[8:5]))
        else $error("advert write lost");
    a_adv_ro: assert property (@(posedge clock) disable iff (!rst_b)
        st_r.adv[4:0] == 5'h01 && !st_r.adv[15] && !st_r.adv[13])
        else $error("advert read-only field changed");
    a_spec_write: assert property (@(posedge clock) disable iff (!rst_b)
        host_wr && host_addr == OFF_P1_SPECIAL |=> force_link[0] == $past(host_wdata[3])
            && near_loopback[0] == $past(host_wdata[1]))
        else $error("special write lost");
    a_spec_rsv: assert property (@(posedge clock) disable iff (!rst_b)
        st_r.spec1[15:4] == 12'h000 && !st_r.spec1[0])
        else $error("special reserved bits changed");
    a_gap_zero: assert property (@(posedge clock) disable iff (!rst_b)
        host_rd && (host_addr == OFF_RSV_A || host_addr == OFF_RSV_B) |=> host_rdata == ZERO16)
        else $error("reserved gap not zero");

    ////////////////////////////////////////////////////////////////////////////
    // further read and write checks
    a_basic_rsv: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_basic |=> (host_rdata & 16'h0790) == ZERO16)
        else $error("basic status reserved bits set");
    a_basic_link_dn: assert property (@(posedge clock) disable iff (!rst_b)
        s_link_down_steady ##0 s_read_basic |=> !host_rdata[2])
        else $error("link bit set while down");
    a_basic_aneg_up: assert property (@(posedge clock) disable iff (!rst_b)
        s_aneg_up_steady ##0 s_read_basic |=> host_rdata[5])
        else $error("aneg done bit clear when done");
    a_basic_aneg_dn: assert property (@(posedge clock) disable iff (!rst_b)
        s_aneg_down_steady ##0 s_read_basic |=> !host_rdata[5])
        else $error("aneg done bit set when not done");
    a_ident_high: assert property (@(posedge clock) disable iff (!rst_b)
        host_rd && host_addr == OFF_P2_ID_HI |=> host_rdata == ID_HI_VAL)
        else $error("ident high wrong");
    a_adv_read: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_adv |=> host_rdata[10] == $past(adv_pause)
            && host_rdata[8:5] == $past(adv_abil))
        else $error("advert readback differs from controls");
    a_adv_fixed_rd: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_adv |=> host_rdata[4:0] == 5'h01
            && host_rdata[15:11] == 5'h00 && !host_rdata[9])
        else $error("advert fixed fields wrong");
    a_adv_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !(host_wr && host_addr == OFF_P2_ADV) |=> $stable(adv_pause)
            && $stable(adv_abil))
        else $error("advert controls changed without write");
    a_partner_pause: assert property (@(posedge clock) disable iff (!rst_b)
        partner_pause[1] [*3] ##0 s_read_partner |=> host_rdata[10])
        else $error("partner pause bit clear");
    a_partner_abil: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_partner |=> host_rdata[8:5] == $past(st_r.pa_s))
        else $error("partner ability bits wrong");
    a_partner_fixed: assert property (@(posedge clock) disable iff (!rst_b)
        s_read_partner |=> host_rdata[4:0] == 5'h01
            && host_rdata[15:11] == 5'h00 && !host_rdata[9])
        else $error("partner fixed fields wrong");
    a_spec_polarity: assert property (@(posedge clock) disable iff (!rst_b)
        phy_pol_rev[0] [*3] ##0 s_read_spec1 |=> host_rdata[5])
        else $error("polarity bit clear");
    a_spec_mdix: assert property (@(posedge clock) disable iff (!rst_b)
        phy_mdix[0] [*3] ##0 s_read_spec1 |=> host_rdata[4])
        else $error("crossover bit clear");
    a_spec_lp10: assert property (@(posedge clock) disable iff (!rst_b)
        host_wr && host_addr == OFF_P1_SPECIAL |=> low_power_10mb_mode_dis[0] == $past(host_wdata[2]))
        else $error("low power disable write lost");
    a_spec_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !(host_wr && host_addr == OFF_P1_SPECIAL) |=> $stable(force_link[0])
            && $stable(low_power_10mb_mode_dis[0]) && $stable(near_loopback[0]))
        else $error("special controls changed without write");
    a_spec2_write: assert property (@(posedge clock) disable iff (!rst_b)
        host_wr && host_addr == OFF_P2_SPECIAL |=> force_link[1] == $past(host_wdata[3])
            && low_power_10mb_mode_dis[1] == $past(host_wdata[2]) && near_loopback[1] == $past(host_wdata[1]))
        else $error("port2 special write lost");
    a_spec2_status: assert property (@(posedge clock) disable iff (!rst_b)
        phy_pol_rev[1] [*3] ##0 s_read_spec2 |=> host_rdata[5])
        else $error("port2 polarity bit clear");
    a_spec2_rsv: assert property (@(posedge clock) disable iff (!rst_b)
        st_r.spec2[15:4] == 12'h000 && !st_r.spec2[0])
        else $error("port2 special reserved bits changed");
    a_read_valid: assert property (@(posedge clock) disable iff (!rst_b)
        host_rd |=> host_rvalid)
        else $error("read not answered");
    a_idle_rdata: assert property (@(posedge clock) disable iff (!rst_b)
        !host_rd |=> !host_rvalid && host_rdata == ZERO16)
        else $error("read data without read");
endmodule

//--- pps_host_model.sv
// pps_host_model: host side of the parallel register port
// assumes one clock shared with the bank; strobes are one-cycle pulses
`timescale 1ns/1ps
module pps_host_model (
    // clock
    input wire logic clock,
    // host access
    output logic host_wr,
    output logic host_rd,
    output logic [pps_pkg::AW-1:0] host_addr,
    output logic [pps_pkg::DW-1:0] host_wdata,
    input wire logic [pps_pkg::DW-1:0] host_rdata,
    input wire logic host_rvalid
);
    import pps_pkg::*;
    initial begin
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = '0;
        host_wdata = '0;
    end
    ////////////////////////////////////////////////////////////////
    // idle address shows the inverse of the last transfer; idle data the inverse of the last write
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clock);
        host_wr <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic v);
        @(posedge clock);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clock);
        host_rd <= 1'b0;
        host_addr <= ~a;
        // take the answer at the edge where rvalid is sampled high
        @(posedge clock);
        d = host_rdata;
        v = host_rvalid;
    endtask
endmodule

//--- tb.sv
// tb: register reads and writes against the port status bank
// assumes a host model drives the access port; status pins driven here
`timescale 1ns/1ps
module tb;
    import pps_pkg::*;
    logic clock;
    logic rst_b;
    logic host_wr;
    logic host_rd;
    logic [AW-1:0] host_addr;
    logic [DW-1:0] host_wdata;
    logic [DW-1:0] host_rdata;
    logic host_rvalid;
    logic [1:0] aneg;
    logic [1:0] link;
    logic [1:0] pol;
    logic [1:0] mdix;
    logic [1:0] ppause;
    logic [7:0] pabil;
    logic [1:0] force_link;
    logic [1:0] lp10_dis;
    logic [1:0] loopb;
    logic adv_pause;
    logic [3:0] adv_abil;
    int err_count;
    int n_compared;
    logic [11:0] ad [10] = '{12'h005a, 12'h005c, 12'h005e, 12'h0060, 12'h0062,
        12'h0064, 12'h0066, 12'h0068, 12'h006a, 12'h0070};
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    pps_host_model host (.clock(clock), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
    pps_status_regs dut (.clock(clock), .rst_b(rst_b), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .phy_aneg_done(aneg), .phy_link_up(link), .phy_pol_rev(pol),
        .phy_mdix(mdix), .partner_pause(ppause), .partner_abil(pabil), .force_link(force_link),
        .low_power_10mb_mode_dis(lp10_dis), .near_loopback(loopb), .adv_pause(adv_pause),
        .adv_abil(adv_abil));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] e);
        n_compared++;
        if (seen !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic [15:0] ev(input logic [11:0] a, input logic [15:0] d, input logic s);
        case (a)
            12'h005a: return 16'h7808 | (s ? 16'h0024 : 16'h0000);
            12'h005c: return ID_LO_VAL;
            12'h005e: return ID_HI_VAL;
            12'h0060: return 16'h0001 | (d & 16'h05e0);
            12'h0062: return 16'h0001 | (s ? 16'h0540 : 16'h0000);
            12'h0066, 12'h006a: return (d & 16'h000e) | (s ? 16'h0030 : 16'h0000);
            default: return 16'h0000;
        endcase
    endfunction
    // status s on port2 (port1 opposite where unseen), optional write of d everywhere, read all back
    task automatic run_pass(input logic [15:0] d, input logic s, input logic w);
        logic [15:0] q;
        logic v;
        @(posedge clock);
        aneg <= {s, ~s};
        link <= {s, ~s};
        pol <= {s, s};
        mdix <= {s, s};
        ppause <= {s, ~s};
        pabil <= s ? 8'ha5 : 8'h0f;
        repeat (4) @(posedge clock);
        if (w) begin
            for (int i = 0; i < 10; i++) host.wr(ad[i], d);
        end
        for (int i = 0; i < 10; i++) begin
            host.rd(ad[i], q, v);
            check("rvalid", {15'h0, v}, 16'h0001);
            check("rd", q, ev(ad[i], d, s));
        end
        check("pause", {15'h0, adv_pause}, {15'h0, d[10]});
        check("abil", {12'h0, adv_abil}, {12'h0, d[8:5]});
        check("force", {14'h0, force_link}, {14'h0, {2{d[3]}}});
        check("lp10", {14'h0, lp10_dis}, {14'h0, {2{d[2]}}});
        check("loop", {14'h0, loopb}, {14'h0, {2{d[1]}}});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        aneg = 2'b00;
        link = 2'b00;
        pol = 2'b00;
        mdix = 2'b00;
        ppause = 2'b00;
        pabil = 8'h00;
        err_count = 0;
        n_compared = 0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        run_pass(16'h05e4, 1'b0, 1'b0);
        run_pass(16'h0000, 1'b0, 1'b1);
        run_pass(16'hffff, 1'b0, 1'b1);
        run_pass(16'hffff, 1'b1, 1'b0);
        run_pass(16'h0000, 1'b1, 1'b1);
        wrap_up;
    end
    initial begin
        repeat (4000) @(posedge clock);
        err_count++;
        wrap_up;
    end
endmodule
